// file: hdl/pic_pkg.sv
// package for the peripheral interrupt control block
// assumes a 32-bit apb slave with one register per aligned word
package pic_pkg;
   // register byte offsets
   localparam logic [7:0] PIC_OFS_INTCTL1 = 8'h00;
   localparam logic [7:0] PIC_OFS_INTCTL2 = 8'h04;
   localparam logic [7:0] PIC_OFS_INTCTL3 = 8'h08;
   localparam logic [7:0] PIC_OFS_PIE_A   = 8'h0c;
   localparam logic [7:0] PIC_OFS_PIE_B   = 8'h10;
   localparam logic [7:0] PIC_OFS_PIP_A   = 8'h14;
   localparam logic [7:0] PIC_OFS_PIP_B   = 8'h18;
   localparam logic [7:0] PIC_OFS_RCC     = 8'h1c;
   localparam logic [7:0] PIC_OFS_PFLAG_A = 8'h20;
   localparam logic [7:0] PIC_OFS_PFLAG_B = 8'h24;
   localparam logic [7:0] PIC_OFS_TMR0    = 8'h28;
   localparam logic [7:0] PIC_OFS_PWR     = 8'h2c;
   // field positions, first control register
   localparam int PIC_B_GLOBAL_EN = 7;
   localparam int PIC_B_GROUP_EN  = 6;
   localparam int PIC_B_T0IE   = 5;
   localparam int PIC_B_X0IE   = 4;
   localparam int PIC_B_PBC_EN = 3;
   localparam int PIC_B_T0IF   = 2;
   localparam int PIC_B_X0IF   = 1;
   localparam int PIC_B_PBC_FLAG = 0;
   // second control register
   localparam int PIC_B_EDG0   = 6;
   localparam int PIC_B_EDG1   = 5;
   localparam int PIC_B_EDG2   = 4;
   localparam int PIC_B_T0IP   = 2;
   localparam int PIC_B_PBC_PRIO = 0;
   // third control register
   localparam int PIC_B_X2IP   = 7;
   localparam int PIC_B_X1IP   = 6;
   localparam int PIC_B_X2IE   = 4;
   localparam int PIC_B_X1IE   = 3;
   localparam int PIC_B_X2IF   = 1;
   localparam int PIC_B_X1IF   = 0;
   // reset-control register
   localparam int PIC_B_PRIO_MODE   = 7;
   localparam int PIC_B_SOFT_BO     = 6;
   localparam int PIC_B_WDT_TIMEOUT = 3;
   localparam int PIC_B_PWR_DOWN    = 2;
   localparam int PIC_B_UNIMPL = 5;
   // reset values and masks
   localparam logic [7:0] PIC_RST_CTL1 = 8'h00;
   localparam logic [7:0] PIC_RST_CTL2 = 8'hf5;
   localparam logic [7:0] PIC_MSK_CTL2 = 8'hf5;
   localparam logic [7:0] PIC_RST_CTL3 = 8'hc0;
   localparam logic [7:0] PIC_MSK_CTL3 = 8'hdb;
   localparam logic [7:0] PIC_RST_PIE  = 8'h00;
   localparam logic [7:0] PIC_RST_PIP  = 8'hff;
   localparam logic [7:0] PIC_MSK_B    = 8'hdf;
   localparam logic [7:0] PIC_RST_RCC  = 8'h1c;
   localparam logic [7:0] PIC_MSK_RCCW = 8'hd3;
   localparam logic [7:0] PIC_RST_T0   = 8'h00;
   // apb request bundle
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } pic_apb_req_s;
   // core-side request bundle
   typedef struct packed {
      logic irq_high;
      logic irq_low;
      logic wake;
      logic vector;
   } pic_core_s;
endpackage : pic_pkg

// file: hdl/pic_top.sv
// peripheral interrupt control: enables, priorities, reset-control, pin,
// timer-0 and port-change sources, and high/low requests to the core.
// assumes synchronous inputs on clock and an apb master on the bus side.
// Behaviour
// - without priority mode, peripheral sources need the group enable too
// - two 8-bit peripheral enable registers, reset 0, second bit 5 reads 0
// - two 8-bit peripheral priority registers, reset 1 except second bit 5 (reads 0), 1 means high
// - priority bits only act in priority mode, else one level
// - priority-mode enable is reset-control bit 7, resets 0
// - reset-control holds cause flags; timeout and power-down read-only, power up 1
// - soft brown-out enable resets to 1 when option set, else 0
// - external pins edge-triggered; select 1 rising, 0 falling
// - selected edge sets pin flag; clear enable suppresses request
// - enabled external pin edge wakes the core from idle or sleep
// - after wake, vector only if global enable set
// - ext 1 and 2 priorities are third control bits 6 and 7
// - ext 0 always high priority
// - 8-bit timer-0 rollover FFh to 00h sets the overflow flag
// - 16-bit timer-0 rollover FFFFh to 0000h sets the flag
// - timer-0 gated by first control bit 5, priority second bit 2
// - change on port-b pins 7:4 sets first control bit 0
// - port-change gated by first bit 3, priority second bit 0
// - flags set regardless of enables
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module pic_top
   import pic_pkg::*;
#(
   parameter bit SOFT_BO_OPTION = 1'b0
) (
   input  wire logic                 clock,
   input  wire logic                 arst_n,
   input  wire pic_pkg::pic_apb_req_s apb_req,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   input  wire logic [2:0]           ext_pin,
   input  wire logic [3:0]           portb_hi,
   input  wire logic                 timer0_tick,
   input  wire logic [7:0]           periph_flag_a,
   input  wire logic [7:0]           periph_flag_b,
   input  wire logic                 core_asleep,
   output pic_pkg::pic_core_s        core_req
);
   import pic_pkg::*;

   // reset release through two flops
   logic rst_m_r, rst_n_r;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_m_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_n_r <= rst_m_r;
      end
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   logic [7:0]  ctl1_r, ctl2_r, ctl3_r, pie_a_r, pie_b_r, pip_a_r, pip_b_r, rcc_r;
   logic [15:0] t0_cnt_r;
   logic        t0_16bit_r;
   logic [2:0]  pin_d_r;
   logic [3:0]  rb_d_r;

   // bus decode
   wire         acc      = apb_req.psel & apb_req.penable;
   wire         wr       = acc & pready & apb_req.pwrite;   // write lands on the completing edge only
   wire [7:0]   a        = apb_req.paddr;
   wire [7:0]   wd       = apb_req.pwdata[7:0];
   wire         mapped   = hit(a, PIC_OFS_INTCTL1) | hit(a, PIC_OFS_INTCTL2) | hit(a, PIC_OFS_INTCTL3)
                         | hit(a, PIC_OFS_PIE_A) | hit(a, PIC_OFS_PIE_B) | hit(a, PIC_OFS_PIP_A)
                         | hit(a, PIC_OFS_PIP_B) | hit(a, PIC_OFS_RCC) | hit(a, PIC_OFS_PFLAG_A)
                         | hit(a, PIC_OFS_PFLAG_B) | hit(a, PIC_OFS_TMR0) | hit(a, PIC_OFS_PWR);

   // edge and change detection
   wire [2:0]   edge_sel = {ctl2_r[PIC_B_EDG2], ctl2_r[PIC_B_EDG1], ctl2_r[PIC_B_EDG0]};
   wire [2:0]   rise     = ext_pin & ~pin_d_r;
   wire [2:0]   fall     = ~ext_pin & pin_d_r;
   wire [2:0]   pin_evt  = (rise & edge_sel) | (fall & ~edge_sel);
   wire         rb_evt   = |(portb_hi ^ rb_d_r);

   // timer-0 rollover in either width
   wire [15:0]  t0_next  = t0_cnt_r + 16'h0001;
   wire         t0_ovf8  = timer0_tick & ~t0_16bit_r & (t0_cnt_r[7:0] == 8'hff);
   wire         t0_ovf16 = timer0_tick & t0_16bit_r & (t0_cnt_r == 16'hffff);
   wire         t0_evt   = t0_ovf8 | t0_ovf16;

   // flag next values; set wins over a software clear
   wire [7:0]   ctl1_w   = wr && hit(a, PIC_OFS_INTCTL1) ? wd : ctl1_r;
   wire [7:0]   ctl3_w   = wr && hit(a, PIC_OFS_INTCTL3) ? (wd & PIC_MSK_CTL3) : ctl3_r;
   wire [7:0]   ctl1_nxt = ctl1_w | {5'h00, t0_evt, pin_evt[0], rb_evt};
   wire [7:0]   ctl3_nxt = ctl3_w | {6'h00, pin_evt[2], pin_evt[1]};

   // register file
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ctl1_r  <= PIC_RST_CTL1;
         ctl2_r  <= PIC_RST_CTL2;
         ctl3_r  <= PIC_RST_CTL3;
         pie_a_r <= PIC_RST_PIE;
         pie_b_r <= PIC_RST_PIE;
         pip_a_r <= PIC_RST_PIP;
         pip_b_r <= PIC_RST_PIP & PIC_MSK_B;
         rcc_r   <= PIC_RST_RCC | {1'b0, SOFT_BO_OPTION, 6'h00};
      end else begin
         ctl1_r <= ctl1_nxt;
         ctl3_r <= ctl3_nxt;
         if (wr && hit(a, PIC_OFS_INTCTL2)) ctl2_r <= wd & PIC_MSK_CTL2;
         if (wr && hit(a, PIC_OFS_PIE_A))   pie_a_r <= wd;
         if (wr && hit(a, PIC_OFS_PIE_B))   pie_b_r <= wd & PIC_MSK_B;
         if (wr && hit(a, PIC_OFS_PIP_A))   pip_a_r <= wd;
         if (wr && hit(a, PIC_OFS_PIP_B))   pip_b_r <= wd & PIC_MSK_B;
         if (wr && hit(a, PIC_OFS_RCC))
            rcc_r <= (wd & PIC_MSK_RCCW) | (rcc_r & ~PIC_MSK_RCCW);
      end
   end

   // timer-0 counter and samplers
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         t0_cnt_r   <= {PIC_RST_T0, PIC_RST_T0};
         t0_16bit_r <= 1'b0;
         pin_d_r    <= 3'h0;
         rb_d_r     <= 4'h0;
      end else begin
         pin_d_r <= ext_pin;
         rb_d_r  <= portb_hi;
         if (wr && hit(a, PIC_OFS_TMR0)) begin
            t0_cnt_r   <= apb_req.pwdata[15:0];
            t0_16bit_r <= apb_req.pwdata[16];
         end else if (timer0_tick)
            t0_cnt_r <= t0_16bit_r ? t0_next : {8'h00, t0_next[7:0]};
      end
   end

   // source requests: flag and enable
   wire prio_mode = rcc_r[PIC_B_PRIO_MODE];
   wire global_en = ctl1_r[PIC_B_GLOBAL_EN];
   wire group_en  = ctl1_r[PIC_B_GROUP_EN];
   wire x0_req  = ctl1_r[PIC_B_X0IF] & ctl1_r[PIC_B_X0IE];
   wire x1_req  = ctl3_r[PIC_B_X1IF] & ctl3_r[PIC_B_X1IE];
   wire x2_req  = ctl3_r[PIC_B_X2IF] & ctl3_r[PIC_B_X2IE];
   wire t0_req  = ctl1_r[PIC_B_T0IF] & ctl1_r[PIC_B_T0IE];
   wire rb_req  = ctl1_r[PIC_B_PBC_FLAG] & ctl1_r[PIC_B_PBC_EN];
   wire [7:0] pa_req = periph_flag_a & pie_a_r;
   wire [7:0] pb_req = periph_flag_b & pie_b_r & PIC_MSK_B;

   // priority routing, only in priority mode
   wire core_hi = x0_req
                | (x1_req & ctl3_r[PIC_B_X1IP]) | (x2_req & ctl3_r[PIC_B_X2IP])
                | (t0_req & ctl2_r[PIC_B_T0IP]) | (rb_req & ctl2_r[PIC_B_PBC_PRIO]);
   wire core_lo = (x1_req & ~ctl3_r[PIC_B_X1IP]) | (x2_req & ~ctl3_r[PIC_B_X2IP])
                | (t0_req & ~ctl2_r[PIC_B_T0IP]) | (rb_req & ~ctl2_r[PIC_B_PBC_PRIO]);
   wire per_hi  = |(pa_req & pip_a_r) | |(pb_req & pip_b_r);
   wire per_lo  = |(pa_req & ~pip_a_r) | |(pb_req & ~pip_b_r);
   wire any_core = x0_req | x1_req | x2_req | t0_req | rb_req;
   wire any_per  = |pa_req | |pb_req;
   // priority mode: global enable gates high, group enable gates low too
   wire hi_nxt  = prio_mode ? (global_en & (core_hi | per_hi))
                            : (global_en & (any_core | (group_en & any_per)));
   wire lo_nxt  = prio_mode & global_en & group_en & (core_lo | per_lo);
   wire ext_en  = (ctl1_r[PIC_B_X0IE] & pin_evt[0]) | (ctl3_r[PIC_B_X1IE] & pin_evt[1])
                | (ctl3_r[PIC_B_X2IE] & pin_evt[2]);
   wire wake_nxt = core_asleep & (ext_en | any_core | any_per);

   // core outputs
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) core_req <= '0;
      else begin
         core_req.irq_high <= hi_nxt;
         core_req.irq_low  <= lo_nxt;
         core_req.wake     <= wake_nxt;
         core_req.vector   <= wake_nxt & global_en;
      end
   end

   // read mux
   logic [7:0] rd;
   always_comb begin
      rd = 8'h00;
      if (hit(a, PIC_OFS_INTCTL1)) rd = ctl1_r;
      if (hit(a, PIC_OFS_INTCTL2)) rd = ctl2_r;
      if (hit(a, PIC_OFS_INTCTL3)) rd = ctl3_r;
      if (hit(a, PIC_OFS_PIE_A))   rd = pie_a_r;
      if (hit(a, PIC_OFS_PIE_B))   rd = pie_b_r;
      if (hit(a, PIC_OFS_PIP_A))   rd = pip_a_r;
      if (hit(a, PIC_OFS_PIP_B))   rd = pip_b_r;
      if (hit(a, PIC_OFS_RCC))     rd = rcc_r;
      if (hit(a, PIC_OFS_PFLAG_A)) rd = periph_flag_a;
      if (hit(a, PIC_OFS_PFLAG_B)) rd = periph_flag_b & PIC_MSK_B;
   end
   wire [31:0] rd32 = hit(a, PIC_OFS_TMR0) ? {15'h0, t0_16bit_r, t0_cnt_r}
                    : hit(a, PIC_OFS_PWR) ? {31'h0, core_asleep} : {24'h0, rd};

   // apb answer: one wait state, registered outputs
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc & ~pready;
         prdata  <= (acc & ~pready & ~apb_req.pwrite) ? rd32 : 32'h00000000;
         pslverr <= acc & ~pready & ~mapped;
      end
   end

   // checks
   a_group_gate: assert property (@(posedge clock) disable iff (!rst_n_r)
      (!prio_mode && !any_core && !group_en) |=> !core_req.irq_high)
      else $error("peripheral request passed without group enable");
   a_pin_flag_set: assert property (@(posedge clock) disable iff (!rst_n_r)
      pin_evt[1] |=> ctl3_r[PIC_B_X1IF])
      else $error("ext one flag not set on edge");
   a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n_r)
      (ctl3_r[PIC_B_X2IF] && !(wr && hit(a, PIC_OFS_INTCTL3))) |=> ctl3_r[PIC_B_X2IF])
      else $error("ext two flag cleared by hardware");
   a_t0_ovf: assert property (@(posedge clock) disable iff (!rst_n_r)
      t0_ovf8 |=> ctl1_r[PIC_B_T0IF] && t0_cnt_r[7:0] == 8'h00)
      else $error("timer rollover flag missing");
   a_t0_ovf16: assert property (@(posedge clock) disable iff (!rst_n_r)
      t0_ovf16 |=> ctl1_r[PIC_B_T0IF] && t0_cnt_r == 16'h0000)
      else $error("wide timer rollover flag missing");
   a_rb_change: assert property (@(posedge clock) disable iff (!rst_n_r)
      $changed(portb_hi) |=> ctl1_r[PIC_B_PBC_FLAG])
      else $error("port change flag missing");
   a_rb_route_hi: assert property (@(posedge clock) disable iff (!rst_n_r)
      (prio_mode && global_en && rb_req && ctl2_r[PIC_B_PBC_PRIO]) |=> core_req.irq_high)
      else $error("port change not routed high");
   a_rb_route_lo: assert property (@(posedge clock) disable iff (!rst_n_r)
      (prio_mode && global_en && group_en && rb_req && !ctl2_r[PIC_B_PBC_PRIO]) |=> core_req.irq_low)
      else $error("port change not routed low");
   a_no_low_single: assert property (@(posedge clock) disable iff (!rst_n_r)
      !prio_mode |=> !core_req.irq_low)
      else $error("low request in single level mode");
   a_group_low: assert property (@(posedge clock) disable iff (!rst_n_r)
      (prio_mode && !group_en) |=> !core_req.irq_low)
      else $error("low request without group enable");
   a_x0_high: assert property (@(posedge clock) disable iff (!rst_n_r)
      (x0_req && global_en) |=> core_req.irq_high)
      else $error("ext zero not high priority");
   a_pin_wake: assert property (@(posedge clock) disable iff (!rst_n_r)
      (core_asleep && ctl1_r[PIC_B_X0IE] && pin_evt[0]) |=> core_req.wake)
      else $error("enabled pin edge did not wake the core");
   a_vector_global: assert property (@(posedge clock) disable iff (!rst_n_r)
      core_req.vector |-> core_req.wake && $past(global_en))
      else $error("vector without global enable");
   a_pie_b_bit5: assert property (@(posedge clock) disable iff (!rst_n_r)
      !pie_b_r[5] && !pip_b_r[5])
      else $error("unimplemented bit set");
   a_rcc_ro: assert property (@(posedge clock) disable iff (!rst_n_r)
      $stable(rcc_r[PIC_B_WDT_TIMEOUT]) && $stable(rcc_r[PIC_B_PWR_DOWN]) && !rcc_r[PIC_B_UNIMPL])
      else $error("read-only reset flag changed");
endmodule : pic_top

// file: verification/pic_core_model.sv
// partner: processor core and peripheral sources around the block
// assumes the bench calls its tasks from procedural code
`timescale 1ns/10ps
module pic_core_model (
   input  wire logic  clock,
   output logic [2:0] ext_pin,
   output logic [3:0] portb_hi,
   output logic       timer0_tick,
   output logic [7:0] periph_flag_a,
   output logic [7:0] periph_flag_b,
   output logic       core_asleep
);
   // quiet sources at time zero
   initial begin
      ext_pin = 3'h0;
      portb_hi = 4'h0;
      timer0_tick = 1'b0;
      periph_flag_a = 8'h00;
      periph_flag_b = 8'h00;
      core_asleep = 1'b0;
   end
   // change pins, flags and sleep state just after an edge
   task automatic drive(input logic [2:0] p, input logic [3:0] b, input logic [7:0] f, input logic s);
      @(posedge clock);
      ext_pin <= p;
      portb_hi <= b;
      periph_flag_a <= f;
      core_asleep <= s;
      repeat (2) @(posedge clock);
   endtask : drive
   // one-cycle increment pulses with a gap between them
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clock);
         timer0_tick <= 1'b1;
         @(posedge clock);
         timer0_tick <= 1'b0;
      end
      repeat (2) @(posedge clock);
   endtask : ticks
endmodule : pic_core_model

// file: verification/peripheral_interrupt_control_test.sv
// self-checking bench for the peripheral interrupt control block
// assumes pic_top answers apb with one wait state and the partner model
`timescale 1ns/10ps
module peripheral_interrupt_control_test;
   import pic_pkg::*;
   localparam logic [7:0] PIC_OFS_CTL1 = PIC_OFS_INTCTL1;
   localparam logic [7:0] PIC_OFS_CTL2 = PIC_OFS_INTCTL2;
   localparam logic [7:0] PIC_OFS_CTL3 = PIC_OFS_INTCTL3;
   logic         clock = 1'b0;
   logic         arst_n;
   pic_apb_req_s req = '0;
   logic         pready, pslverr, err, tick;
   logic [31:0]  prdata, rd, lfsr = 32'h34442046;
   logic [31:0]  prdata_bo, rd_bo;
   logic [2:0]   pins;
   logic [3:0]   pb;
   logic [7:0]   fa, fb;
   logic         sleep;
   pic_core_s    core;
   int           bad_count = 0, n_compared = 0, cycles = 0;
   logic [7:0]   ra [7] = '{PIC_OFS_PIE_A, PIC_OFS_PIE_B, PIC_OFS_PIP_A, PIC_OFS_PIP_B,
                            PIC_OFS_RCC, PIC_OFS_CTL2, PIC_OFS_CTL3};
   logic [7:0]   rv [7] = '{8'h00, 8'h00, 8'hff, 8'hdf, 8'h1c, 8'hf5, 8'hc0};
   pic_top #(.SOFT_BO_OPTION(1'b0)) dut (.clock(clock), .arst_n(arst_n), .apb_req(req), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .ext_pin(pins), .portb_hi(pb), .timer0_tick(tick),
      .periph_flag_a(fa), .periph_flag_b(fb), .core_asleep(sleep), .core_req(core));
   // second copy strapped with the soft brown-out option
   pic_top #(.SOFT_BO_OPTION(1'b1)) dut_bo (.clock(clock), .arst_n(arst_n), .apb_req(req), .pready(),
      .prdata(prdata_bo), .pslverr(), .ext_pin(pins), .portb_hi(pb), .timer0_tick(tick),
      .periph_flag_a(fa), .periph_flag_b(fb), .core_asleep(sleep), .core_req());
   pic_core_model m (.clock(clock), .ext_pin(pins), .portb_hi(pb), .timer0_tick(tick),
      .periph_flag_a(fa), .periph_flag_b(fb), .core_asleep(sleep));
   // free-running clock and hang guard
   always #5 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         bad_count++;
         end_of_test();
      end
   end
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_step
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, held until pready is seen at an edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clock);
      req.penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      rd_bo = prdata_bo;
      err = pslverr;
      req <= '0;
      @(posedge clock);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d});
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, {24'h0, e});
   endtask : rdc
   // let registered requests settle, then compare {high, low}
   task automatic req_chk(input logic [1:0] e);
      repeat (3) @(posedge clock);
      #1;
      chk({30'h0, core.irq_high, core.irq_low}, {30'h0, e});
   endtask : req_chk
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   // main sequence
   initial begin
      arst_n <= 1'b0;
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      for (int i = 0; i < 7; i++) rdc(ra[i], rv[i]);
      rdc(PIC_OFS_RCC, 8'h1c);
      chk(rd_bo, 32'h0000005c);
      $display("reset values done");
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_step(lfsr);
         wr(PIC_OFS_PIE_B, lfsr[7:0]);
         rdc(PIC_OFS_PIE_B, lfsr[7:0] & 8'hdf);
         wr(PIC_OFS_PIP_A, lfsr[15:8]);
         rdc(PIC_OFS_PIP_A, lfsr[15:8]);
      end
      wr(PIC_OFS_PIE_B, 8'h00);
      wr(PIC_OFS_PIP_A, 8'hff);
      wr(PIC_OFS_RCC, 8'hff);
      rdc(PIC_OFS_RCC, 8'hdf);
      wr(PIC_OFS_RCC, 8'h00);
      rdc(PIC_OFS_RCC, 8'h0c);
      rdc(8'h3c, 8'h00);
      chk({31'h0, err}, 32'h1);
      $display("register access done");
      m.drive(3'b111, 4'h0, 8'h00, 1'b0);
      rdc(PIC_OFS_CTL1, 8'h02);
      rdc(PIC_OFS_CTL3, 8'hc3);
      wr(PIC_OFS_CTL2, 8'h85);
      wr(PIC_OFS_CTL1, 8'h00);
      wr(PIC_OFS_CTL3, 8'hc0);
      m.drive(3'b000, 4'h0, 8'h00, 1'b0);
      rdc(PIC_OFS_CTL1, 8'h02);
      rdc(PIC_OFS_CTL3, 8'hc3);
      wr(PIC_OFS_CTL1, 8'h00);
      wr(PIC_OFS_CTL3, 8'hc0);
      m.drive(3'b111, 4'h0, 8'h00, 1'b0);
      rdc(PIC_OFS_CTL1, 8'h00);
      wr(PIC_OFS_CTL2, 8'hf5);
      $display("edge pins done");
      m.ticks(255);
      rdc(PIC_OFS_CTL1, 8'h00);
      m.ticks(1);
      rdc(PIC_OFS_CTL1, 8'h04);
      lfsr = lfsr_step(lfsr);
      m.drive(3'b111, lfsr[3:0] | 4'h1, 8'h00, 1'b0);
      rdc(PIC_OFS_CTL1, 8'h05);
      wr(PIC_OFS_CTL1, 8'h00);
      bus(1'b1, PIC_OFS_TMR0, 32'h000100ff);
      m.ticks(1);
      rdc(PIC_OFS_CTL1, 8'h00);
      bus(1'b1, PIC_OFS_TMR0, 32'h0001ffff);
      m.ticks(1);
      rdc(PIC_OFS_CTL1, 8'h04);
      bus(1'b0, PIC_OFS_TMR0, 32'h00000000);
      chk(rd, 32'h00010000);
      $display("timer and port change done");
      m.drive(3'b111, lfsr[3:0] | 4'h1, 8'h01, 1'b0);
      wr(PIC_OFS_PIE_A, 8'h01);
      wr(PIC_OFS_CTL1, 8'h80);
      repeat (3) @(posedge clock);
      #1;
      chk({31'h0, core.irq_high | core.irq_low}, 32'h0);
      wr(PIC_OFS_CTL1, 8'hc0);
      repeat (3) @(posedge clock);
      #1;
      chk({31'h0, core.irq_high | core.irq_low}, 32'h1);
      wr(PIC_OFS_RCC, 8'h80);
      wr(PIC_OFS_PIP_A, 8'h00);
      req_chk(2'b01);
      wr(PIC_OFS_PIP_A, 8'hff);
      req_chk(2'b10);
      wr(PIC_OFS_PIE_A, 8'h00);
      req_chk(2'b00);
      $display("request routing done");
      wr(PIC_OFS_CTL1, 8'h10);
      m.drive(3'b110, 4'h1, 8'h00, 1'b1);
      m.drive(3'b111, 4'h1, 8'h00, 1'b1);
      #1;
      chk({30'h0, core.wake, core.vector}, 32'h2);
      wr(PIC_OFS_CTL1, 8'h92);
      req_chk(2'b10);
      chk({30'h0, core.wake, core.vector}, 32'h3);
      $display("wake done");
      wr(PIC_OFS_CTL2, 8'hf4);
      wr(PIC_OFS_CTL1, 8'hc9);
      req_chk(2'b01);
      wr(PIC_OFS_CTL2, 8'hf5);
      req_chk(2'b10);
      $display("port change priority done");
      end_of_test();
   end
endmodule : peripheral_interrupt_control_test
